/* hdl/rcwdg_top.sv */
// Runaway code watchdog with APB register access
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps

// How it works
// - 6-bit counter fed by 12-bit prescaler
// - Overflow at limit issues reset, two limits
// - Any write to clear address restarts
// - Clear address reads reset vector low byte
// - Timeout drives reset pin 32 ticks, flags
// - Stop instruction clears prescaler
// - Prescaler cleared 4096 ticks after power-up
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears prescaler
// - Disable and long select follow config
// - Monitor mode plus test voltage disables
// - Break plus test voltage on reset disables
// - No interrupt to the CPU, reset only
// - Keeps counting in wait mode
// - Stop gates crystal ticks, clears prescaler
// - Stop honoured only when stop enable set
// - Crystal ticks derived at crystal rate
// - Enable output returns when voltage removed
module rcwdg_top #(
   parameter logic [17:0] LIMIT_SHORT = rcwdg_pkg::LIMIT_SHORT,
   parameter logic [17:0] LIMIT_LONG = rcwdg_pkg::LIMIT_LONG,
   parameter logic [12:0] POR_TICKS = rcwdg_pkg::POR_TICKS
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU side status, same clock
   input wire logic internal_reset,
   input wire logic stop_exec,
   input wire logic wait_mode,
   input wire logic [15:0] cpu_addr,
   input wire logic vec_fetch,
   input wire logic [7:0] reset_vector_lo,
   input wire logic monitor_mode,
   input wire logic break_state,
   // Test voltage detectors, asynchronous
   input wire logic hv_irq_pin,
   input wire logic hv_rst_pin,
   // Reset pin, open drain
   output logic rst_pin_o,
   output logic rst_pin_oe,
   // System outputs
   output logic wdg_reset,
   output logic wdg_enable,
   output logic stop_active,
   output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function automatic logic is_vec_addr(input logic [15:0] a);
   is_vec_addr = (a == rcwdg_pkg::VEC_HI_ADDR) ||
                 (a == rcwdg_pkg::VEC_LO_ADDR);
endfunction : is_vec_addr

function automatic logic is_reg(input logic [17:0] a, input logic [17:0] r);
   is_reg = (a == r);
endfunction : is_reg

////////////////////////////////////////////////////////////////////////////////
// Declarations

logic [1:0] hv_sync;
rcwdg_pkg::rcwdg_mode_t mode;
rcwdg_pkg::rcwdg_cfg_t cfg_q;
logic [2:0] mask_q;
logic [2:0] stat_q;
logic [2:0] stat_d;
logic [2:0] evt;
rcwdg_pkg::rcwdg_bus_t bus_q;
logic [3:0] div_q;
logic xtal_tick;
logic [11:0] pre_q;
logic [5:0] cnt_q;
logic [17:0] total;
logic [17:0] limit;
logic [12:0] por_q;
logic por_clr;
logic [5:0] pin_q;
logic wdg_off;
logic stop_req;
logic stop_q;
logic stop_entry;
logic vec_clr;
logic expire;
logic access;
logic wr_acc;
logic rd_acc;
logic hit_cfg;
logic hit_stat;
logic hit_mask;
logic hit_count;
logic hit_clear;
logic hit_any;
logic clear_wr;
logic pre_clr;
logic [31:0] rd_mux;

////////////////////////////////////////////////////////////////////////////////
// Pin inputs

rcwdg_sync #(
   .WIDTH(2)
) u_sync (
   .pclk(pclk),
   .presetn(presetn),
   .async_i({hv_irq_pin, hv_rst_pin}),
   .sync_o(hv_sync)
);

assign mode = '{monitor: monitor_mode, brk: break_state,
                hv_irq: hv_sync[1], hv_rst: hv_sync[0]};

// Monitor mode with test voltage, break with voltage on reset pin
assign wdg_off = cfg_q.disable_bit
   | (mode.monitor & (mode.hv_irq | mode.hv_rst))
   | (mode.brk & mode.hv_rst);

////////////////////////////////////////////////////////////////////////////////
// Crystal tick and gating

// Ticks stand in for the crystal clock; one pclk domain only
assign xtal_tick = (div_q == 4'(rcwdg_pkg::XTAL_DIV - 1))
   & !stop_q;

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      div_q <= 4'h0;
   else if (xtal_tick || div_q == 4'(rcwdg_pkg::XTAL_DIV - 1))
      div_q <= 4'h0;
   else
      div_q <= div_q + 4'h1;
end

// Stop instruction ignored unless enabled
assign stop_req = stop_exec & cfg_q.stop_en;
assign stop_entry = stop_req & !stop_q;

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      stop_q <= 1'b0;
   else
      stop_q <= stop_req;
end

////////////////////////////////////////////////////////////////////////////////
// Power-on delay

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      por_q <= 13'h0000;
   else if (xtal_tick && por_q != POR_TICKS)
      por_q <= por_q + 13'h0001;
end

assign por_clr = xtal_tick && (por_q == POR_TICKS - 13'h0001);

////////////////////////////////////////////////////////////////////////////////
// Prescaler and counter

assign vec_clr = vec_fetch & is_vec_addr(cpu_addr);
assign pre_clr = stop_entry
   | por_clr | vec_clr | internal_reset;
assign total = {cnt_q, pre_q};
assign limit = cfg_q.long_sel ? LIMIT_LONG : LIMIT_SHORT;
// Wait mode is deliberately not a term here
assign expire = xtal_tick & !wdg_off
   & (total >= limit - 18'h0_0001);

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pre_q <= 12'h000;
      cnt_q <= 6'h00;
   end
   else if (wdg_off || internal_reset || expire)
   begin
      pre_q <= 12'h000;
      cnt_q <= 6'h00;
   end
   else if (clear_wr)
   begin
      pre_q[11:rcwdg_pkg::CLR_LO] <= 9'h000;
      cnt_q <= 6'h00;
   end
   else if (pre_clr)
      pre_q <= 12'h000;
   else if (xtal_tick)
   begin
      pre_q <= pre_q + 12'h001;
      if (pre_q == 12'hfff)
         cnt_q <= cnt_q + 6'h01;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Reset pulse and pin

// Pin is open drain; only the enable moves
always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pin_q <= 6'h00;
      rst_pin_oe <= 1'b0;
      rst_pin_o <= 1'b0;
      wdg_reset <= 1'b0;
   end
   else
   begin
      wdg_reset <= expire;
      rst_pin_o <= 1'b0;
      if (expire)
      begin
         pin_q <= rcwdg_pkg::PIN_LOW_TICKS;
         rst_pin_oe <= 1'b1;
      end
      else if (xtal_tick && pin_q != 6'h00)
      begin
         pin_q <= pin_q - 6'h01;
         rst_pin_oe <= (pin_q != 6'h01);
      end
   end
end

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      wdg_enable <= 1'b0;
      stop_active <= 1'b0;
   end
   else
   begin
      wdg_enable <= !wdg_off;
      stop_active <= stop_q;
   end
end

////////////////////////////////////////////////////////////////////////////////
// APB decode

assign access = psel & penable & (bus_q == rcwdg_pkg::RCWDG_SETUP);
assign wr_acc = access & pwrite;
assign rd_acc = access & !pwrite;
assign hit_cfg = is_reg(paddr, rcwdg_pkg::CFG_ADDR);
assign hit_stat = is_reg(paddr, rcwdg_pkg::STAT_ADDR);
assign hit_mask = is_reg(paddr, rcwdg_pkg::MASK_ADDR);
assign hit_count = is_reg(paddr, rcwdg_pkg::COUNT_ADDR);
assign hit_clear = is_reg(paddr, rcwdg_pkg::CLEAR_ADDR);
assign hit_any = hit_cfg | hit_stat | hit_mask | hit_count | hit_clear;
assign clear_wr = wr_acc & hit_clear;

// Clear location never shows watchdog state
assign rd_mux = hit_clear ? {24'h00_0000, reset_vector_lo}
   : hit_cfg ? {29'h0000_0000, cfg_q}
   : hit_stat ? {29'h0000_0000, stat_q}
   : hit_mask ? {29'h0000_0000, mask_q}
   : hit_count ? {14'h0000, total}
   : 32'h0000_0000;

// One wait state: answer lands on the second access cycle
always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      bus_q <= rcwdg_pkg::RCWDG_IDLE;
   else
      unique case (bus_q)
         rcwdg_pkg::RCWDG_IDLE:
            bus_q <= (psel && !penable) ? rcwdg_pkg::RCWDG_SETUP
                                        : rcwdg_pkg::RCWDG_IDLE;
         rcwdg_pkg::RCWDG_SETUP:
            bus_q <= access ? rcwdg_pkg::RCWDG_DONE
                            : rcwdg_pkg::RCWDG_SETUP;
         rcwdg_pkg::RCWDG_DONE:
            bus_q <= rcwdg_pkg::RCWDG_IDLE;
         default:
            bus_q <= rcwdg_pkg::RCWDG_IDLE;
      endcase
end

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
   end
   else
   begin
      pready <= access;
      pslverr <= access & !hit_any;
      prdata <= rd_acc ? rd_mux : 32'h0000_0000;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registers and events

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      cfg_q <= rcwdg_pkg::CFG_RESET;
      mask_q <= rcwdg_pkg::MASK_RESET;
   end
   else
   begin
      if (wr_acc && hit_cfg)
         cfg_q <= pwdata[2:0];
      if (wr_acc && hit_mask)
         mask_q <= pwdata[2:0];
   end
end

assign evt[rcwdg_pkg::EVT_TIMEOUT] = expire;
assign evt[rcwdg_pkg::EVT_STOP_CLR] = stop_entry;
assign evt[rcwdg_pkg::EVT_POR_CLR] = por_clr;

// New events win over a same-cycle clear
assign stat_d = (stat_q & ~((wr_acc && hit_stat) ? pwdata[2:0] : 3'h0))
   | evt;

always_ff @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      stat_q <= 3'h0;
      irq <= 1'b0;
   end
   else
   begin
      stat_q <= stat_d;
      // Status line for system logic, not a CPU request
      irq <= |(stat_d & mask_q);
   end
end

endmodule : rcwdg_top

/* pkg/rcwdg_pkg.sv */
// Shared constants and types of the runaway code watchdog
package rcwdg_pkg;

////////////////////////////////////////////////////////////////////////////////
// Bus and register map

localparam int unsigned ADDR_W = 18;
localparam logic [15:0] CLEAR_INDEX = 16'hffff;
localparam logic [17:0] CLEAR_ADDR = {CLEAR_INDEX, 2'b00};
localparam logic [17:0] CFG_ADDR = 18'h0_0000;
localparam logic [17:0] STAT_ADDR = 18'h0_0004;
localparam logic [17:0] MASK_ADDR = 18'h0_0008;
localparam logic [17:0] COUNT_ADDR = 18'h0_000c;

////////////////////////////////////////////////////////////////////////////////
// Field layout

localparam int unsigned CFG_DISABLE_BIT = 0;
localparam int unsigned CFG_LONG_BIT = 1;
localparam int unsigned CFG_STOP_EN_BIT = 2;
localparam logic [2:0] CFG_RESET = 3'h0;
localparam int unsigned EVT_W = 3;
localparam int unsigned EVT_TIMEOUT = 0;
localparam int unsigned EVT_STOP_CLR = 1;
localparam int unsigned EVT_POR_CLR = 2;
localparam logic [2:0] MASK_RESET = 3'h0;

////////////////////////////////////////////////////////////////////////////////
// Counter widths and timing

localparam int unsigned PRE_W = 12;
localparam int unsigned CNT_W = 6;
localparam int unsigned TOT_W = PRE_W + CNT_W;
localparam int unsigned CLR_LO = 3;
localparam int unsigned CLK_HZ = 40_000_000;
localparam int unsigned XTAL_HZ = 5_000_000;
localparam int unsigned XTAL_DIV = CLK_HZ / XTAL_HZ;
localparam logic [17:0] LIMIT_SHORT = 18'h0_1ff0;
localparam logic [17:0] LIMIT_LONG = 18'h3_fff0;
localparam logic [12:0] POR_TICKS = 13'h1000;
localparam logic [5:0] PIN_LOW_TICKS = 6'h20;
localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
localparam logic [15:0] VEC_LO_ADDR = 16'hffff;

////////////////////////////////////////////////////////////////////////////////
// Carriers

typedef struct packed {
   logic stop_en;
   logic long_sel;
   logic disable_bit;
} rcwdg_cfg_t;

typedef struct packed {
   logic monitor;
   logic brk;
   logic hv_irq;
   logic hv_rst;
} rcwdg_mode_t;

typedef enum logic [1:0] {
   RCWDG_IDLE = 2'b00,
   RCWDG_SETUP = 2'b01,
   RCWDG_DONE = 2'b11
} rcwdg_bus_t;

endpackage : rcwdg_pkg

/* hdl/rcwdg_sync.sv */
// Three stage input synchroniser with agreement filter
`timescale 1ns/100ps
module rcwdg_sync #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

////////////////////////////////////////////////////////////////////////////////

logic [WIDTH-1:0] s1_q;
logic [WIDTH-1:0] s2_q;
logic [WIDTH-1:0] s3_q;

genvar gi;
generate
   for (gi = 0; gi < WIDTH; gi++)
   begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            s1_q[gi] <= 1'b0;
            s2_q[gi] <= 1'b0;
            s3_q[gi] <= 1'b0;
            sync_o[gi] <= 1'b0;
         end
         else
         begin
            s1_q[gi] <= async_i[gi];
            s2_q[gi] <= s1_q[gi];
            s3_q[gi] <= s2_q[gi];
            // Only accept once two late stages agree
            if (s2_q[gi] == s3_q[gi])
               sync_o[gi] <= s3_q[gi];
         end
      end
   end
endgenerate

endmodule : rcwdg_sync

/* sim/rcwdg_assertions.sv */
// Port checks of the runaway code watchdog
`timescale 1ns/100ps
module rcwdg_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Modes
   input wire logic stop_exec,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic hv_irq_pin,
   input wire logic hv_rst_pin,
   // Outputs
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic wdg_reset,
   input wire logic wdg_enable,
   input wire logic stop_active
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////
// Pin low time; tick phase allows one tick of slack
logic [9:0] low_q;
logic [9:0] low_d;
assign low_d = rst_pin_oe ? low_q + 10'h001 : 10'h000;
always_ff @(posedge pclk or negedge presetn)
   if (!presetn)
      low_q <= 10'h000;
   else
      low_q <= low_d;
////////////////////
property p_wait; psel && penable && !pready |=> pready; endproperty
a_wait: assert property (p_wait) else $error("no answer");
property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
a_err: assert property (p_err) else $error("data on error");
property p_drv; rst_pin_oe |-> !rst_pin_o; endproperty
a_drv: assert property (p_drv) else $error("pin driven high");
property p_start; wdg_reset |-> ##[0:2] rst_pin_oe; endproperty
a_start: assert property (p_start) else $error("pin not low");
property p_len; $fell(rst_pin_oe) |-> $past(low_q) inside {[248:264]};
endproperty
a_len: assert property (p_len) else $error("pin low time");
property p_once; wdg_reset |=> !wdg_reset; endproperty
a_once: assert property (p_once) else $error("long reset");
property p_off; !wdg_enable && $past(!wdg_enable) |-> !wdg_reset;
endproperty
a_off: assert property (p_off) else $error("reset while off");
property p_mon; (monitor_mode && hv_irq_pin) [*6] |-> !wdg_enable;
endproperty
a_mon: assert property (p_mon) else $error("monitor on");
property p_brk; (break_state && hv_rst_pin) [*6] |-> !wdg_enable;
endproperty
a_brk: assert property (p_brk) else $error("break on");
property p_stop; $rose(stop_active) |-> $past(stop_exec, 2); endproperty
a_stop: assert property (p_stop) else $error("stray stop");
endmodule : rcwdg_assertions

bind rcwdg_top rcwdg_assertions u_chk (.*);

/* sim/rcwdg_partner.sv */
// Reset logic on the far side of the reset pin
`timescale 1ns/100ps
module rcwdg_partner (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Reset pin
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   // System reset and pin reset count
   output logic internal_reset,
   output logic [7:0] pin_resets
);
// Pulled up when released
logic pin_n;
logic low_q;
assign pin_n = rst_pin_oe ? rst_pin_o : 1'b1;
// One pulse per pin fall, so the pin timer is never cut short
always_ff @(posedge pclk or negedge presetn)
   if (!presetn)
   begin
      low_q <= 1'b0;
      internal_reset <= 1'b0;
      pin_resets <= 8'h00;
   end
   else
   begin
      low_q <= !pin_n;
      internal_reset <= !pin_n && !low_q;
      pin_resets <= pin_resets + {7'h00, !pin_n && !low_q};
   end
endmodule : rcwdg_partner

/* sim/rcwdg_top_test.sv */
// Self-checking bench of the runaway code watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module rcwdg_top_test;
typedef struct packed {
   logic wr;
   logic [17:0] addr;
   logic [31:0] data;
   logic [31:0] exp;
   logic err;
} rcwdg_row_t;
localparam logic [17:0] SHORT = 18'h0_0040;
localparam logic [17:0] LONG = 18'h0_0080;
localparam rcwdg_row_t ROWS [7] = '{
   '{1'b0, rcwdg_pkg::CFG_ADDR, 32'h0, 32'h0, 1'b0},
   '{1'b0, rcwdg_pkg::MASK_ADDR, 32'h0, 32'h0, 1'b0},
   '{1'b1, rcwdg_pkg::CFG_ADDR, 32'h2, 32'h0, 1'b0},
   '{1'b0, rcwdg_pkg::CFG_ADDR, 32'h0, 32'h2, 1'b0},
   '{1'b0, 18'h0_0010, 32'h0, 32'h0, 1'b1},
   '{1'b1, 18'h0_0014, 32'h7, 32'h0, 1'b1},
   '{1'b0, rcwdg_pkg::CLEAR_ADDR, 32'h0, 32'h5a, 1'b0}};
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [17:0] paddr = 18'h0;
logic [31:0] pwdata = 32'h0;
logic stop_exec = 1'b0;
logic wait_mode = 1'b0;
logic [15:0] cpu_addr = 16'h0;
logic vec_fetch = 1'b0;
logic [7:0] reset_vector_lo = 8'h5a;
logic monitor_mode = 1'b0;
logic break_state = 1'b0;
logic hv_irq_pin = 1'b0;
logic hv_rst_pin = 1'b0;
logic [31:0] prdata;
logic pready, pslverr, internal_reset, rst_pin_o, rst_pin_oe;
logic wdg_reset, wdg_enable, stop_active, irq;
logic [7:0] pin_resets;
logic [31:0] rd;
logic er;
int err_count = 0;
int num_checks = 0;
int n;
rcwdg_top #(.LIMIT_SHORT(SHORT), .LIMIT_LONG(LONG),
   .POR_TICKS(13'h0010)) uut (.*);
rcwdg_partner u_far (.*);
always #12.5 pclk = ~pclk;
////////////////////
task conclude;
   if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
   else
      $display("DONE - FAIL");
   $finish;
endtask : conclude
task automatic apb(input logic w, input logic [17:0] a,
   input logic [31:0] d);
   int k;
   k = 0;
   @(posedge pclk);
   psel <= 1'b1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1'b1;
   // Answer is taken only at a rising edge that shows pready high
   do
   begin
      @(posedge pclk);
      k++;
   end
   while (pready !== 1'b1 && k < 20);
   if (pready !== 1'b1)
   begin
      err_count++;
      conclude();
   end
   rd = prdata;
   er = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask : apb
// Pre bits [2:0] survive a clear, hence the slack
task automatic expire(input logic [17:0] lim);
   n = 0;
   while (wdg_reset !== 1'b1 && n < 1200)
   begin
      @(negedge pclk);
      n++;
   end
   `CHK(n >= 8 * (lim - 8) && n <= 8 * lim + 16, 1'b1)
   if (n >= 1200)
      conclude();
endtask : expire
////////////////////
initial
begin
   repeat (8) @(posedge pclk);
   presetn <= 1'b1;
   foreach (ROWS[i])
   begin
      apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data);
      `CHK(er, ROWS[i].err)
      if (!ROWS[i].wr)
         `CHK(rd, ROWS[i].exp)
   end
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h0);
   repeat (120) @(negedge pclk);
   apb(1'b0, rcwdg_pkg::STAT_ADDR, 32'h0);
   `CHK(rd[rcwdg_pkg::EVT_POR_CLR], 1'b1)
   `CHK(irq, 1'b0)
   apb(1'b1, rcwdg_pkg::MASK_ADDR, 32'h4);
   repeat (3) @(negedge pclk);
   `CHK(irq, 1'b1)
   apb(1'b1, rcwdg_pkg::STAT_ADDR, 32'h4);
   repeat (3) @(negedge pclk);
   `CHK(irq, 1'b0)
   apb(1'b1, rcwdg_pkg::MASK_ADDR, 32'h7);
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h1);
   wait_mode <= 1'b1;
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h0);
   apb(1'b1, rcwdg_pkg::CLEAR_ADDR, 32'h0);
   expire(SHORT);
   repeat (4) @(negedge pclk);
   `CHK(pin_resets, 8'h01)
   `CHK(irq, 1'b1)
   `CHK(rst_pin_oe, 1'b1)
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h1);
   repeat (700) @(negedge pclk);
   apb(1'b0, rcwdg_pkg::COUNT_ADDR, 32'h0);
   `CHK(rd, 32'h0)
   `CHK(wdg_enable, 1'b0)
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h2);
   expire(LONG);
   repeat (300) @(negedge pclk);
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h0);
   // Each service must hold off expiry only until the next one, 300 cycles later
   for (int i = 0; i < 4; i++)
   begin
      apb(1'b1, rcwdg_pkg::CLEAR_ADDR, 32'h0);
      repeat (300) @(posedge pclk);
   end
   `CHK(pin_resets, 8'h02)
   for (int i = 0; i < 4; i++)
   begin
      cpu_addr <= i[0] ? rcwdg_pkg::VEC_LO_ADDR : rcwdg_pkg::VEC_HI_ADDR;
      vec_fetch <= 1'b1;
      @(posedge pclk);
      vec_fetch <= 1'b0;
      repeat (300) @(posedge pclk);
   end
   `CHK(pin_resets, 8'h02)
   monitor_mode <= 1'b1;
   hv_irq_pin <= 1'b1;
   repeat (10) @(negedge pclk);
   `CHK(wdg_enable, 1'b0)
   @(posedge pclk);
   hv_irq_pin <= 1'b0;
   repeat (10) @(negedge pclk);
   `CHK(wdg_enable, 1'b1)
   @(posedge pclk);
   monitor_mode <= 1'b0;
   break_state <= 1'b1;
   hv_rst_pin <= 1'b1;
   repeat (10) @(negedge pclk);
   `CHK(wdg_enable, 1'b0)
   @(posedge pclk);
   break_state <= 1'b0;
   hv_rst_pin <= 1'b0;
   stop_exec <= 1'b1;
   repeat (10) @(negedge pclk);
   `CHK(stop_active, 1'b0)
   apb(1'b1, rcwdg_pkg::CFG_ADDR, 32'h4);
   repeat (4) @(negedge pclk);
   `CHK(stop_active, 1'b1)
   apb(1'b0, rcwdg_pkg::STAT_ADDR, 32'h0);
   `CHK(rd[rcwdg_pkg::EVT_STOP_CLR], 1'b1)
   repeat (100) @(negedge pclk);
   apb(1'b0, rcwdg_pkg::COUNT_ADDR, 32'h0);
   `CHK(rd, 32'h0)
   stop_exec <= 1'b0;
   conclude();
end
endmodule : rcwdg_top_test
